// [common/ora_pkg.sv]
package ora_pkg;
    localparam int ORA_AW = 12;
    localparam logic [11:0] ORA_CTRL_OFF = 12'h000;
    localparam logic [11:0] ORA_SRC_CFG_OFF = 12'h004;
    localparam logic [11:0] ORA_SRC_ORG_OFF = 12'h008;
    localparam logic [11:0] ORA_DST_CFG_OFF = 12'h00c;
    localparam logic [11:0] ORA_SWZ_OFF = 12'h010;
    localparam logic [11:0] ORA_ARF_OFF = 12'h020;
    localparam logic [11:0] ORA_STAT_OFF = 12'h060;
    localparam logic [11:0] ORA_CHEN_OFF = 12'h064;
    localparam logic [11:0] ORA_ADDR_OFF = 12'h100;
    localparam logic [31:0] ORA_REG_RST = 32'h0000_0000;
    localparam logic [15:0] ORA_ARF_RST = 16'h0000;
    localparam logic [7:0] ORA_SWZ_RST = 8'he4;
    localparam int SC_T0 = 0;
    localparam int SC_T1 = 4;
    localparam int SC_IMM = 8;
    localparam int SC_CH = 9;
    localparam int SC_W = 12;
    localparam int SC_HS = 15;
    localparam int SC_VS = 17;
    localparam int SC_IND = 21;
    localparam int SC_A16 = 22;
    localparam int SC_OP = 23;
    localparam int SC_TWO = 25;
    localparam int SO_REG = 0;
    localparam int SO_SUB = 11;
    localparam int SO_ARF = 16;
    localparam int DC_T = 0;
    localparam int DC_HS = 4;
    localparam int DC_MASK = 6;
    localparam int DC_REG = 10;
    localparam int DC_SUB = 21;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ILL = 2;
    localparam int ST_EX = 3;
    // address register entry: register index above, byte subregister below
    localparam int AE_REG_LSB = 5;
    localparam int ORA_GRF_LOG = 5;
    localparam int ORA_MAX_BYTES_LOG = 6;
    localparam int ORA_A16_ROW_LOG = 2;
    localparam logic [3:0] TY_UB = 4'h0;
    localparam logic [3:0] TY_HF = 4'h8;
    localparam logic [3:0] TY_F = 4'h9;
    localparam logic [3:0] TY_DF = 4'ha;
    localparam logic [3:0] TY_VF = 4'hb;
    localparam logic [3:0] ORA_VS_IND = 4'hf;
    localparam logic [3:0] ORA_VS_MAX = 4'h6;
    localparam logic [1:0] OP_OTHER = 2'h0;
    localparam logic [1:0] OP_RAW = 2'h1;
    localparam logic [1:0] OP_SEL = 2'h2;
    localparam logic [1:0] OP_IEEE = 2'h3;
    localparam logic [2:0] EX_W = 3'h0;
    localparam logic [2:0] EX_D = 3'h1;
    localparam logic [2:0] EX_Q = 3'h2;
    localparam logic [2:0] EX_F = 3'h3;
    localparam logic [2:0] EX_DF = 3'h4;
    localparam logic [2:0] EX_HF = 3'h5;

    typedef enum logic [1:0] {
        ORA_IDLE = 2'b00,
        ORA_CHECK = 2'b01,
        ORA_RUN = 2'b11
    } ora_state_t;

    // log2 of element size in bytes; integer codes 0..7 pair as ub/b, uw/w, ud/d, uq/q
    function automatic logic [1:0] ora_esz(input logic [3:0] t);
        if (t == TY_HF)
            return 2'h1;
        if (t == TY_F || t == TY_VF)
            return 2'h2;
        if (t == TY_DF)
            return 2'h3;
        return t[2:1];
    endfunction

    function automatic logic ora_is_fp(input logic [3:0] t);
        return t[3];
    endfunction

    // step code: 0 gives 0, k gives 2**(k-1)
    function automatic logic [5:0] ora_step(input logic [3:0] c);
        if (c == 4'h0)
            return 6'h00;
        return 6'h01 << (c - 4'h1);
    endfunction
endpackage

// [rtl/ora_agen.sv]
`timescale 1ns/1ps
module ora_agen #(
    parameter int AI = 4,
    parameter int CI = 5
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [2:0] ch_log_i,
    input wire logic [2:0] w_log_i,
    input wire logic [5:0] hs_i,
    input wire logic [5:0] vs_i,
    input wire logic [5:0] dhs_i,
    input wire logic [1:0] esz_i,
    input wire logic [1:0] desz_i,
    input wire logic ind_i,
    input wire logic per_row_i,
    input wire logic a16_i,
    input wire logic [7:0] swz_i,
    input wire logic [15:0] sorg_i,
    input wire logic [15:0] dorg_i,
    input wire logic [AI-1:0] arf_base_i,
    input wire logic [15:0] arf_entry_i,
    output logic [AI-1:0] arf_idx_o,
    output logic valid_o,
    output logic done_o,
    output logic err_o,
    output logic [CI-1:0] ch_o,
    output logic [15:0] src_o,
    output logic [15:0] dst_o
);
    import ora_pkg::*;

    logic run_reg, run_next;
    logic [CI-1:0] ch_reg, ch_next;
    logic [10:0] first_reg, first_next, dfst_reg, dfst_next, row_reg, row_next;

    always_comb
    begin
        logic [CI-1:0] y;
        logic [CI-1:0] x;
        logic [CI-1:0] xe;
        logic [15:0] org;
        logic [15:0] row;
        logic [15:0] s_end;
        logic [15:0] d_end;
        logic bad;
        logic last;
        y = ch_reg >> w_log_i;
        x = ch_reg & CI'((1 << w_log_i) - 1);
        // swizzle picks the element within each group of four
        xe = a16_i ? CI'(swz_i[2 * x[1:0] +: 2]) : x;
        arf_idx_o = per_row_i ? arf_base_i + AI'(y) : arf_base_i;
        org = ind_i ? {arf_entry_i[15:AE_REG_LSB], arf_entry_i[AE_REG_LSB-1:0]} : sorg_i;
        row = per_row_i ? org : org + ((16'(y) * 16'(vs_i)) << esz_i);
        src_o = row + ((16'(xe) * 16'(hs_i)) << esz_i);
        dst_o = dorg_i + ((16'(ch_reg) * 16'(dhs_i)) << desz_i);
        s_end = src_o + ((16'h0001 << esz_i) - 16'h0001);
        d_end = dst_o + ((16'h0001 << desz_i) - 16'h0001);
        first_next = (ch_reg == '0) ? src_o[15:ORA_GRF_LOG] : first_reg;
        dfst_next = (ch_reg == '0) ? dst_o[15:ORA_GRF_LOG] : dfst_reg;
        row_next = (x == '0) ? src_o[15:ORA_GRF_LOG] : row_reg;
        bad = s_end[15:ORA_GRF_LOG] != row_next;
        if (!ind_i && (s_end[15:ORA_GRF_LOG] - first_next > 11'h001
            || d_end[15:ORA_GRF_LOG] - dfst_next > 11'h001))
            bad = 1'b1;
        if (a16_i && x == '0 && row[3:0] != 4'h0)
            bad = 1'b1;
        last = ch_reg == CI'((1 << ch_log_i) - 1);
        valid_o = run_reg & ~bad;
        err_o = run_reg & bad;
        done_o = run_reg & ~bad & last;
        ch_o = ch_reg;
        run_next = run_reg;
        ch_next = ch_reg;
        if (start_i)
        begin
            run_next = 1'b1;
            ch_next = '0;
        end
        else if (run_reg)
        begin
            run_next = ~(bad | last);
            ch_next = ch_reg + CI'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            run_reg <= 1'b0;
            ch_reg <= '0;
            first_reg <= '0;
            dfst_reg <= '0;
            row_reg <= '0;
        end
        else
        begin
            run_reg <= run_next;
            ch_reg <= ch_next;
            first_reg <= first_next;
            dfst_reg <= dfst_next;
            row_reg <= row_next;
        end
    end
endmodule

// [rtl/ora_exec.sv]
`timescale 1ns/1ps
module ora_exec (
    input wire logic [3:0] t0_i,
    input wire logic [3:0] t1_i,
    input wire logic two_i,
    input wire logic imm_i,
    output logic [2:0] ex_type_o,
    output logic [1:0] ex_size_o,
    output logic mix_err_o
);
    import ora_pkg::*;

    always_comb
    begin
        logic f0;
        logic f1;
        logic [1:0] w;
        f0 = ora_is_fp(t0_i);
        f1 = ora_is_fp(t1_i);
        w = ora_esz(t0_i);
        mix_err_o = 1'b0;
        if (two_i && f0 != f1)
            mix_err_o = 1'b1;
        if (two_i && f0 && f1 && t0_i != t1_i
            && !(t0_i == TY_F && t1_i == TY_VF && imm_i))
            mix_err_o = 1'b1;
        if (f0)
        begin
            ex_type_o = (t0_i == TY_HF) ? EX_HF : (t0_i == TY_DF) ? EX_DF : EX_F;
            ex_size_o = ora_esz(t0_i);
        end
        else
        begin
            if (two_i && ora_esz(t1_i) > w)
                w = ora_esz(t1_i);
            if (w == 2'h0)
                w = 2'h1;
            ex_type_o = (w == 2'h1) ? EX_W : (w == 2'h2) ? EX_D : EX_Q;
            ex_size_o = w;
        end
    end
endmodule

// [rtl/ora_region_core.sv]
`timescale 1ns/1ps
// Contract
// - one-origin indirect: entry gives origin only
// - per-row: consecutive entries, count is channels/width
// - entry bits 15:5 register, 4:0 byte
// - vertical step code 0xF selects per-row
// - width one: one entry per channel
// - aligned mode: 16-byte origins, four-element rows
// - aligned mode: swizzle and mask per four
// - element mode: no swizzle, no mask
// - six execution types only
// - integer: signed, word minimum, widest source
// - byte destination at byte zero or one
// - row-major byte addresses from origin and steps
// - destination is one-dimensional, channel count long
module ora_region_core #(
    parameter int ARF_ENTRIES = 16,
    parameter int MAX_CH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ora_pkg::ORA_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic busy_o,
    output logic done_o,
    output logic illegal_o
);
    import ora_pkg::*;

    localparam int AI = $clog2(ARF_ENTRIES);
    localparam int CI = $clog2(MAX_CH);

    if (ARF_ENTRIES != (1 << AI) || AI < 1 || AI > 16
        || MAX_CH != (1 << CI) || CI < 2 || CI > 6)
    begin : g_size_chk
        $error("ora_region_core: unsupported size parameters");
    end

    ora_state_t state_reg, state_next;
    logic [31:0] scfg_reg, scfg_next, sorg_reg, sorg_next, dcfg_reg, dcfg_next;
    logic [7:0] swz_reg, swz_next;
    logic [15:0] arf_reg [ARF_ENTRIES];
    logic [15:0] arf_next [ARF_ENTRIES];
    logic [31:0] mem [MAX_CH];
    logic [MAX_CH-1:0] chen_reg, chen_next;
    logic done_reg, done_next, ill_reg, ill_next;
    logic [2:0] ex_reg, ex_next;
    logic [31:0] rd_reg, rd_next;
    logic err_reg, err_next;

    logic [3:0] t0, t1, dt, vs_c;
    logic [2:0] ch_log, w_log;
    logic [1:0] op, esz0, esz1, dsz, xsz, msz;
    logic [5:0] hs, vs, dhs;
    logic [3:0] dmask;
    logic two, imm, ind, a16, per_row, x_mix, bad;
    logic [2:0] x_type;
    logic [15:0] sorg, dorg, dmis;

    logic setup, wr, idle, start, in_arf, in_mem, hit, ro;
    logic [AI-1:0] arf_wi;
    logic [CI-1:0] mem_ri;

    logic g_start, g_valid, g_done, g_err;
    logic [AI-1:0] g_arf_idx;
    logic [CI-1:0] g_ch;
    logic [15:0] g_src, g_dst;

    assign t0 = scfg_reg[SC_T0 +: 4];
    assign t1 = scfg_reg[SC_T1 +: 4];
    assign imm = scfg_reg[SC_IMM];
    assign ch_log = scfg_reg[SC_CH +: 3];
    assign w_log = scfg_reg[SC_W +: 3];
    assign hs = ora_step({2'b00, scfg_reg[SC_HS +: 2]});
    assign vs_c = scfg_reg[SC_VS +: 4];
    assign vs = ora_step(vs_c);
    assign ind = scfg_reg[SC_IND];
    assign a16 = scfg_reg[SC_A16];
    assign op = scfg_reg[SC_OP +: 2];
    assign two = scfg_reg[SC_TWO];
    assign dt = dcfg_reg[DC_T +: 4];
    assign dhs = ora_step({2'b00, dcfg_reg[DC_HS +: 2]});
    assign dmask = dcfg_reg[DC_MASK +: 4];
    assign per_row = vs_c == ORA_VS_IND;
    assign esz0 = ora_esz(t0);
    assign esz1 = ora_esz(t1);
    assign dsz = ora_esz(dt);
    assign sorg = {sorg_reg[SO_REG +: 11], 5'h00} + (16'(sorg_reg[SO_SUB +: 5]) << esz0);
    assign dorg = {dcfg_reg[DC_REG +: 11], 5'h00} + (16'(dcfg_reg[DC_SUB +: 5]) << dsz);
    assign dmis = dorg & ((16'h0001 << xsz) - 16'h0001);

    ora_exec u_exec (
        .t0_i(t0),
        .t1_i(t1),
        .two_i(two),
        .imm_i(imm),
        .ex_type_o(x_type),
        .ex_size_o(xsz),
        .mix_err_o(x_mix)
    );

    ora_agen #(
        .AI(AI),
        .CI(CI)
    ) u_agen (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .start_i(g_start),
        .ch_log_i(ch_log),
        .w_log_i(w_log),
        .hs_i(hs),
        .vs_i(vs),
        .dhs_i(dhs),
        .esz_i(esz0),
        .desz_i(dsz),
        .ind_i(ind),
        .per_row_i(per_row),
        .a16_i(a16),
        .swz_i(swz_reg),
        .sorg_i(sorg),
        .dorg_i(dorg),
        .arf_base_i(sorg_reg[SO_ARF +: AI]),
        .arf_entry_i(arf_reg[g_arf_idx]),
        .arf_idx_o(g_arf_idx),
        .valid_o(g_valid),
        .done_o(g_done),
        .err_o(g_err),
        .ch_o(g_ch),
        .src_o(g_src),
        .dst_o(g_dst)
    );

    always_comb
    begin
        msz = (two && esz1 > esz0) ? esz1 : esz0;
        if (dsz > msz)
            msz = dsz;
        bad = 1'b0;
        if (a16 && op != OP_IEEE)
            bad = 1'b1;
        if (a16 && (w_log != 3'(ORA_A16_ROW_LOG) || dorg[3:0] != 4'h0
            || (!ind && sorg[3:0] != 4'h0)))
            bad = 1'b1;
        if (x_mix)
            bad = 1'b1;
        if ({1'b0, ch_log} + {2'b00, msz} > 4'(ORA_MAX_BYTES_LOG) || ch_log > 3'(CI))
            bad = 1'b1;
        if (xsz > dsz && dhs != (6'h01 << (xsz - dsz)))
            bad = 1'b1;
        if (xsz > dsz && dmis != 16'h0000 && !(dsz == 2'h0 && dmis == 16'h0001))
            bad = 1'b1;
        if (w_log > ch_log)
            bad = 1'b1;
        if (!per_row && w_log == ch_log && hs != 6'h00 && vs != (hs << w_log))
            bad = 1'b1;
        if (w_log == 3'h0 && hs != 6'h00)
            bad = 1'b1;
        if (!per_row && ch_log == 3'h0 && w_log == 3'h0 && vs != 6'h00)
            bad = 1'b1;
        if (!per_row && vs == 6'h00 && hs == 6'h00 && w_log != 3'h0)
            bad = 1'b1;
        if (dhs == 6'h00)
            bad = 1'b1;
        if (dsz == 2'h0 && dhs == 6'h01 && op != OP_RAW)
            bad = 1'b1;
        if (vs_c > ORA_VS_MAX && !per_row)
            bad = 1'b1;
        if (per_row && (!ind || (w_log <= ch_log && ch_log - w_log > 3'(AI))))
            bad = 1'b1;
    end

    always_comb
    begin
        setup = psel_i & ~penable_i;
        wr = psel_i & penable_i & pwrite_i;
        idle = state_reg == ORA_IDLE;
        start = wr && idle && paddr_i == ORA_CTRL_OFF && pwdata_i[0];
        in_arf = paddr_i >= ORA_ARF_OFF && paddr_i < ORA_ARF_OFF + 12'(ARF_ENTRIES * 4);
        in_mem = paddr_i >= ORA_ADDR_OFF && paddr_i < ORA_ADDR_OFF + 12'(MAX_CH * 4);
        arf_wi = AI'((paddr_i - ORA_ARF_OFF) >> 2);
        mem_ri = CI'((paddr_i - ORA_ADDR_OFF) >> 2);
        ro = in_mem || paddr_i == ORA_STAT_OFF || paddr_i == ORA_CHEN_OFF;
        hit = paddr_i[1:0] == 2'b00 && (in_arf || ro || paddr_i == ORA_CTRL_OFF
            || paddr_i == ORA_SRC_CFG_OFF || paddr_i == ORA_SRC_ORG_OFF
            || paddr_i == ORA_DST_CFG_OFF || paddr_i == ORA_SWZ_OFF);
        rd_next = rd_reg;
        err_next = err_reg;
        if (setup)
        begin
            err_next = ~hit | (pwrite_i & ro);
            rd_next = 32'h0000_0000;
            if (hit && !pwrite_i)
            begin
                if (in_arf)
                    rd_next = {16'h0000, arf_reg[arf_wi]};
                else if (in_mem)
                    rd_next = mem[mem_ri];
                else
                begin
                    unique case (paddr_i)
                        ORA_SRC_CFG_OFF: rd_next = scfg_reg;
                        ORA_SRC_ORG_OFF: rd_next = sorg_reg;
                        ORA_DST_CFG_OFF: rd_next = dcfg_reg;
                        ORA_SWZ_OFF: rd_next = {24'h00_0000, swz_reg};
                        ORA_STAT_OFF: rd_next = 32'({ex_reg, ill_reg, done_reg, ~idle});
                        ORA_CHEN_OFF: rd_next = 32'(chen_reg);
                        default: rd_next = 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    always_comb
    begin
        scfg_next = scfg_reg;
        sorg_next = sorg_reg;
        dcfg_next = dcfg_reg;
        swz_next = swz_reg;
        arf_next = arf_reg;
        if (wr && idle && paddr_i[1:0] == 2'b00)
        begin
            if (paddr_i == ORA_SRC_CFG_OFF)
                scfg_next = pwdata_i;
            if (paddr_i == ORA_SRC_ORG_OFF)
                sorg_next = pwdata_i;
            if (paddr_i == ORA_DST_CFG_OFF)
                dcfg_next = pwdata_i;
            if (paddr_i == ORA_SWZ_OFF)
                swz_next = pwdata_i[7:0];
            if (in_arf)
                arf_next[arf_wi] = pwdata_i[15:0];
        end
    end

    always_comb
    begin
        state_next = state_reg;
        done_next = done_reg;
        ill_next = ill_reg;
        ex_next = ex_reg;
        chen_next = chen_reg;
        g_start = 1'b0;
        unique case (state_reg)
            ORA_IDLE:
            begin
                if (start)
                begin
                    state_next = ORA_CHECK;
                    done_next = 1'b0;
                    ill_next = 1'b0;
                    chen_next = '0;
                end
            end
            ORA_CHECK:
            begin
                ex_next = x_type;
                if (bad)
                begin
                    ill_next = 1'b1;
                    state_next = ORA_IDLE;
                end
                else
                begin
                    g_start = 1'b1;
                    state_next = ORA_RUN;
                end
            end
            ORA_RUN:
            begin
                if (g_valid)
                    chen_next[g_ch] = ~a16 | dmask[g_ch[1:0]];
                if (g_err)
                begin
                    ill_next = 1'b1;
                    chen_next = '0;
                    state_next = ORA_IDLE;
                end
                else if (g_done)
                begin
                    done_next = 1'b1;
                    state_next = ORA_IDLE;
                end
            end
            default:
            begin
                state_next = ORA_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (g_valid)
            mem[g_ch] <= {g_dst, g_src};
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ORA_IDLE;
            scfg_reg <= ORA_REG_RST;
            sorg_reg <= ORA_REG_RST;
            dcfg_reg <= ORA_REG_RST;
            swz_reg <= ORA_SWZ_RST;
            for (int i = 0; i < ARF_ENTRIES; i++)
                arf_reg[i] <= ORA_ARF_RST;
            chen_reg <= '0;
            done_reg <= 1'b0;
            ill_reg <= 1'b0;
            ex_reg <= EX_W;
            rd_reg <= ORA_REG_RST;
            err_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            scfg_reg <= scfg_next;
            sorg_reg <= sorg_next;
            dcfg_reg <= dcfg_next;
            swz_reg <= swz_next;
            arf_reg <= arf_next;
            chen_reg <= chen_next;
            done_reg <= done_next;
            ill_reg <= ill_next;
            ex_reg <= ex_next;
            rd_reg <= rd_next;
            err_reg <= err_next;
        end
    end

    assign prdata_o = rd_reg;
    assign pready_o = 1'b1;
    assign pslverr_o = err_reg & psel_i & penable_i;
    assign busy_o = state_reg != ORA_IDLE;
    assign done_o = done_reg;
    assign illegal_o = ill_reg;
endmodule

// [sim/ora_apb_host.sv]
`timescale 1ns/1ps
module ora_apb_host (
    input wire logic mclk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o
);
    logic hung;
    initial
    begin
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
        hung = 1'b0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int i;
        @(posedge mclk_i);
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'b10, w, a, d};
        @(posedge mclk_i);
        penable_o <= 1'b1;
        @(posedge mclk_i);
        for (i = 0; i < 20 && pready_i !== 1'b1; i++) @(posedge mclk_i);
        hung = i == 20;
        rd = prdata_i;
        err = pslverr_i;
        {psel_o, penable_o, paddr_o, pwdata_o} <= {2'b00, ~a, ~d};
    endtask
endmodule

// [sim/ora_region_chk.sv]
`timescale 1ns/1ps
module ora_region_chk import ora_pkg::*; #(
    parameter int ARF_ENTRIES = 16,
    parameter int MAX_CH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ora_pkg::ORA_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic illegal_o
);
    localparam int BUSY_MAX = MAX_CH + 4;
    logic acc_w, start_w;
    logic [31:0] scfg_reg, dcfg_reg;
    logic [6:0] cnt_reg;
    assign acc_w = psel_i && penable_i && pwrite_i && pready_o && !busy_o;
    assign start_w = acc_w && paddr_i == ORA_CTRL_OFF && pwdata_i[0];
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scfg_reg <= '0;
            dcfg_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (acc_w && paddr_i == ORA_SRC_CFG_OFF)
                scfg_reg <= pwdata_i;
            if (acc_w && paddr_i == ORA_DST_CFG_OFF)
                dcfg_reg <= pwdata_i;
            cnt_reg <= start_w ? 7'h00 : cnt_reg + 7'(busy_o);
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_START_CLEARS: assert property (start_w |=> busy_o && !done_o && !illegal_o)
        else $error("start did not clear status");
    AST_DONE_COUNT: assert property ($rose(done_o) |->
        cnt_reg == (7'h01 << scfg_reg[SC_CH+:3]) + 7'h01) else $error("run length wrong");
    AST_DONE_NOT_ILL: assert property (done_o |-> !illegal_o && !busy_o)
        else $error("done with illegal or busy");
    AST_BUSY_BOUND: assert property ($rose(busy_o) |-> ##[1:BUSY_MAX] !busy_o)
        else $error("run too long");
    AST_ILL_STOPS: assert property ($rose(illegal_o) |-> !busy_o && $past(busy_o))
        else $error("illegal outside a run");
    AST_STICKY: assert property (!busy_o && !start_w |=> $stable(done_o) && $stable(illegal_o))
        else $error("status changed while idle");
    AST_WIDTH_CHECK: assert property (start_w && scfg_reg[SC_W+:3] > scfg_reg[SC_CH+:3]
        |=> ##1 illegal_o) else $error("width above channels accepted");
    AST_DST_STEP: assert property (start_w && dcfg_reg[DC_HS+:2] == 2'h0
        |=> ##1 illegal_o && !done_o) else $error("zero destination step accepted");
    cover property ($rose(done_o));
    cover property ($rose(illegal_o));
    cover property (pslverr_o);
endmodule
bind ora_region_core ora_region_chk #(.ARF_ENTRIES(ARF_ENTRIES), .MAX_CH(MAX_CH)) u_chk (.*);

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import ora_pkg::*;
    logic mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, busy_o, done_o, illegal_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd, c, o, d;
    logic err;
    logic [15:0] arf [16];
    logic [31:0] cl [7], dl [7], sm [7], ci [11], di [11], oi [11];
    logic [2:0] ex [7];
    int n_fail = 0, compares = 0, seed = 32'h2a62_851b, r, t, n, k;
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    ora_region_core DUT (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o), .done_o(done_o),
        .illegal_o(illegal_o));
    ora_apb_host host (.mclk_i(mclk_i), .pready_i(pready_o), .pslverr_i(pslverr_o),
        .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
        .paddr_o(paddr_i), .pwdata_o(pwdata_i));
    task summarize;
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task xf(input logic w, input logic [11:0] a, input logic [31:0] dat);
        host.xfer(w, a, dat, rd, err);
        n_fail += host.hung;
        if (host.hung)
            summarize();
    endtask
    function automatic int st(input int s);
        return s == 0 ? 0 : 1 << (s - 1);
    endfunction
    function automatic int esz(input logic [3:0] ty);
        return ty == TY_F ? 4 : 1 << ty[2:1];
    endfunction
    function automatic logic [31:0] mk(input int ty, ch, w, hs, vs, ind, a16, op);
        return ty | ty << SC_T1 | ch << SC_CH | w << SC_W | hs << SC_HS | vs << SC_VS
            | ind << SC_IND | a16 << SC_A16 | op << SC_OP;
    endfunction
    // src0 byte address of channel ch, row-major, rows from entries when per-row
    function automatic logic [15:0] exp_src(input logic [31:0] cf, og, input int ch);
        int w, y, b;
        logic [15:0] e;
        w = 1 << cf[SC_W+:3];
        y = ch / w;
        e = arf[og[SO_ARF+:4] + (cf[SC_VS+:4] == ORA_VS_IND ? y : 0)];
        b = cf[SC_IND] ? e[15:5] * 32 + e[4:0] : og[10:0] * 32 + og[SO_SUB+:5] * esz(cf[3:0]);
        if (cf[SC_VS+:4] != ORA_VS_IND)
            b += y * st(cf[SC_VS+:4]) * esz(cf[3:0]);
        return 16'(b + ch % w * st(cf[SC_HS+:2]) * esz(cf[3:0]));
    endfunction
    task run(input logic [31:0] cf, og, dc);
        int i;
        xf(1'b1, ORA_SRC_CFG_OFF, cf);
        xf(1'b1, ORA_SRC_ORG_OFF, og);
        xf(1'b1, ORA_DST_CFG_OFF, dc);
        xf(1'b1, ORA_CTRL_OFF, 32'h0000_0001);
        #1;
        for (i = 0; i < 60 && busy_o !== 1'b0; i++) @(posedge mclk_i);
        n_fail += i == 60;
        if (i == 60)
            summarize();
    endtask
    initial
    begin
        rst_i = 1'b1;
        cl = '{mk(3, 3, 3, 1, 4, 0, 0, 0), mk(1, 4, 2, 2, 5, 0, 0, 0), mk(3, 3, 2, 1, 3, 1, 0, 0),
            mk(3, 3, 1, 1, 15, 1, 0, 0), mk(3, 3, 0, 0, 15, 1, 0, 0), mk(3, 3, 3, 1, 4, 0, 0, 0),
            mk(9, 3, 2, 1, 3, 0, 1, 3)};
        dl = '{32'h13, 32'h13, 32'h13, 32'h13, 32'h13, 32'h0020_0021, 32'h19};
        sm = '{7, 7, 0, 0, 0, 7, 0};
        ex = '{EX_W, EX_W, EX_W, EX_W, EX_W, EX_W, EX_F};
        ci = '{mk(3, 2, 3, 1, 4, 0, 0, 0), cl[0], mk(3, 3, 0, 1, 4, 0, 0, 0),
            mk(5, 5, 3, 1, 4, 0, 0, 0), mk(1, 3, 3, 1, 4, 0, 0, 0), mk(9, 3, 2, 1, 3, 0, 1, 0),
            cl[6] ^ 32'h0240_00a0, mk(3, 3, 3, 1, 7, 0, 0, 0), cl[0], cl[6],
            mk(1, 4, 2, 2, 6, 0, 0, 0)};
        di = '{32'h13, 32'h03, 32'h13, 32'h15, 32'h11, 32'h19, 32'h19, 32'h13, 32'h13, 32'h19,
            32'h13};
        oi = '{0, 0, 0, 0, 0, 0, 0, 0, 9 << SO_SUB, 1 << SO_SUB, 0};
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        xf(1'b0, ORA_SWZ_OFF, 32'h0);
        chk(rd, 32'h0000_00e4);
        xf(1'b0, 12'h068, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
        xf(1'b1, ORA_STAT_OFF, 32'h7);
        chk({31'h0, err}, 32'h1);
        for (k = 0; k < 16; k++)
        begin
            arf[k] = 16'({$random(seed)} % 16 << 5 | {$random(seed)} % 8 * 2);
            xf(1'b1, 12'(ORA_ARF_OFF + 4 * k), {16'h0, arf[k]});
        end
        for (r = 0; r < 14; r++)
        begin
            t = r % 7;
            c = cl[t];
            o = {$random(seed)} % 16 | ({$random(seed)} & sm[t]) << SO_SUB | {$random(seed)} % 8 << SO_ARF;
            d = dl[t] | {$random(seed)} % 16 << DC_REG | {$random(seed)} % 16 << DC_MASK;
            run(c, o, d);
            xf(1'b0, ORA_STAT_OFF, 32'h0);
            chk(rd & 32'h0000_003f, {26'h0, ex[t], 3'b010});
            n = 1 << c[SC_CH+:3];
            xf(1'b0, ORA_CHEN_OFF, 32'h0);
            chk(rd, c[SC_A16] ? {8{d[DC_MASK+:4]}} & 32'((1 << n) - 1) : 32'((1 << n) - 1));
            for (k = 0; k < n; k++)
            begin
                xf(1'b0, 12'(ORA_ADDR_OFF + 4 * k), 32'h0);
                chk(rd, {16'(d[DC_REG+:11] * 32 + d[DC_SUB+:5] * esz(d[3:0]) + k * st(d[DC_HS+:2])
                    * esz(d[3:0])), exp_src(c, o, k)});
            end
            $display("region test %0d done", r);
        end
        for (t = 0; t < 11; t++)
        begin
            run(ci[t], oi[t], di[t]);
            xf(1'b0, ORA_STAT_OFF, 32'h0);
            chk(rd & 32'h0000_0007, 32'h0000_0004);
            xf(1'b0, ORA_CHEN_OFF, 32'h0);
            chk(rd, 32'h0);
            $display("illegal test %0d done", t);
        end
        summarize();
    end
endmodule
